// File: hdl/prs_pkg.sv
package prs_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_CONTRAST = 8'h08;
    localparam logic [7:0] ADDR_BP_PSI = 8'h0c;
    localparam logic [7:0] ADDR_BP_TIME = 8'h10;
    localparam logic [7:0] ADDR_OFF_THR = 8'h14;
    localparam logic [7:0] ADDR_ON_LONG = 8'h18;
    localparam logic [7:0] ADDR_ON_SHORT = 8'h1c;
    localparam logic [7:0] ADDR_SHUTOFF = 8'h20;
    localparam logic [7:0] ADDR_MINFREQ = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h2c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h30;
    localparam logic [7:0] ADDR_DATE = 8'h34;
    localparam logic [7:0] ADDR_TIME = 8'h38;
    localparam logic [7:0] ADDR_RTC_KEY = 8'h3c;
    // ctrl fields
    localparam int CTRL_LOCK = 0;
    localparam int CTRL_HAND = 1;
    localparam int CTRL_AUTO = 2;
    localparam int CTRL_CFG_LSB = 4;
    // reset values, limits and config code
    localparam logic [1:0] SEL1_RST = 2'h1;
    localparam logic [1:0] SEL2_RST = 2'h1;
    localparam logic [5:0] CONTRAST_RST = 6'h28;
    localparam logic [5:0] CONTRAST_MIN = 6'h1e;
    localparam logic [5:0] CONTRAST_MAX = 6'h3f;
    localparam logic [7:0] BP_PSI_RST = 8'h00;
    localparam logic [7:0] BP_PSI_MAX = 8'h96;
    localparam logic [13:0] BP_TIME_RST = 14'h0000;
    localparam logic [13:0] BP_TIME_MAX = 14'h270f;
    localparam logic [9:0] OFF_THR_RST = 10'h01e;
    localparam logic [9:0] ON_LONG_RST = 10'h00f;
    localparam logic [9:0] ON_SHORT_RST = 10'h03c;
    localparam logic [9:0] TSEC_MAX = 10'h3e8;
    localparam logic [8:0] SHUTOFF_RST = 9'h00c;
    localparam logic [8:0] SHUTOFF_MAX = 9'h12c;
    localparam logic [2:0] CFG_CP = 3'h1;
    // selector modes
    localparam logic [1:0] SEL_CLOSED_RUN = 2'h0;
    localparam logic [1:0] SEL_CLOSED_STOP = 2'h1;
    localparam logic [1:0] SEL_ALWAYS = 2'h2;
    localparam logic [1:0] SEL_LATCH = 2'h2;
    localparam logic [1:0] SEL_REVERSE = 2'h3;
    // status bits
    localparam int ST_LATCH = 0;
    localparam int ST_BROKEN = 1;
    localparam int ST_SLEEP = 2;
    // tick timing
    localparam int CLK_MHZ = 250;
    localparam int SEC_US = 1000000;
    localparam int SEC_CYCLES = CLK_MHZ * SEC_US;
    localparam int MIN_SECONDS = 60;
    typedef enum logic [1:0] {
        PRS_OFF = 2'b00,
        PRS_AUTO = 2'b01,
        PRS_HAND = 2'b10
    } prs_mode_e;
endpackage

// File: hdl/prs_top.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - lockout yes: only auto and off
// - input one: run, stop, or always
// - input two: closed run or stop
// - input two latch: open faults until enter
// - input two mode three: open reverses
// - settable clock, enter moves, up/down edit
// - contrast default 40, clamp 30 to 63
// - broken pipe threshold zero disables
// - broken pipe after minutes below threshold
// - min on chosen by previous off length
// - on times 15 and 60 default
// - sleep at min frequency plus offset
// - cp features only in cp configuration
// - config zero: both inputs must say run
module prs_top #(
    parameter int SEC_DIV = prs_pkg::SEC_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic contact_one_closed,
    input wire logic contact_two_closed,
    input wire logic key_enter,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic [8:0] pressure_psi,
    input wire logic [8:0] output_freq_hz,
    input wire logic at_setpoint,
    output logic motor_run,
    output logic motor_reverse,
    output logic [5:0] lcd_contrast,
    output logic [1:0] op_mode,
    output logic irq
);
    import prs_pkg::*;

    function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] mx);
        clamp10 = (v > {22'h0, mx}) ? mx : v[9:0];
    endfunction
    function automatic logic [6:0] bump(input logic [6:0] v, input logic up, input logic [6:0] mx);
        if (up) bump = (v >= mx) ? 7'h00 : v + 7'h01;
        else bump = (v == 7'h00) ? mx : v - 7'h01;
    endfunction

    // pin synchronisers
    logic [4:0] s1_ff, s2_ff, kprev_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 5'h00;
            s2_ff <= 5'h00;
            kprev_ff <= 5'h00;
        end else begin
            s1_ff <= {key_down, key_up, key_enter, contact_two_closed, contact_one_closed};
            s2_ff <= s1_ff;
            kprev_ff <= s2_ff;
        end
    end
    wire c1 = s2_ff[0];
    wire c2 = s2_ff[1];
    wire enter_p = s2_ff[2] & ~kprev_ff[2];
    wire up_p = s2_ff[3] & ~kprev_ff[3];
    wire dn_p = s2_ff[4] & ~kprev_ff[4];

    // register file
    logic lock_ff, hand_req_ff, auto_req_ff;
    logic [2:0] cfg_ff;
    logic [1:0] sel1_ff, sel2_ff;
    logic [7:0] bp_psi_ff;
    logic [13:0] bp_time_ff;
    logic [9:0] off_thr_ff, on_long_ff, on_short_ff;
    logic [8:0] shutoff_ff, minfreq_ff;
    logic [2:0] irq_en_ff, status_ff;
    logic rtc_edit_ff;
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    wire cp = (cfg_ff == CFG_CP);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= 1'b1;
            hand_req_ff <= 1'b0;
            auto_req_ff <= 1'b0;
            cfg_ff <= 3'h0;
            sel1_ff <= SEL1_RST;
            sel2_ff <= SEL2_RST;
            lcd_contrast <= CONTRAST_RST;
            bp_psi_ff <= BP_PSI_RST;
            bp_time_ff <= BP_TIME_RST;
            off_thr_ff <= OFF_THR_RST;
            on_long_ff <= ON_LONG_RST;
            on_short_ff <= ON_SHORT_RST;
            shutoff_ff <= SHUTOFF_RST;
            minfreq_ff <= 9'h000;
            irq_en_ff <= 3'h0;
        end else if (wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    lock_ff <= pwdata[CTRL_LOCK];
                    hand_req_ff <= pwdata[CTRL_HAND];
                    auto_req_ff <= pwdata[CTRL_AUTO];
                    cfg_ff <= (pwdata[CTRL_CFG_LSB+:3] > 3'h4) ? 3'h4 : pwdata[CTRL_CFG_LSB+:3];
                end
                ADDR_SEL: begin
                    sel1_ff <= (pwdata[1:0] > SEL_ALWAYS) ? SEL_ALWAYS : pwdata[1:0];
                    sel2_ff <= pwdata[5:4];
                end
                ADDR_CONTRAST: begin
                    if (pwdata > {26'h0, CONTRAST_MAX}) lcd_contrast <= CONTRAST_MAX;
                    else if (pwdata < {26'h0, CONTRAST_MIN}) lcd_contrast <= CONTRAST_MIN;
                    else lcd_contrast <= pwdata[5:0];
                end
                ADDR_BP_PSI: bp_psi_ff <= (pwdata > {24'h0, BP_PSI_MAX}) ? BP_PSI_MAX : pwdata[7:0];
                ADDR_BP_TIME: begin
                    bp_time_ff <= (pwdata > {18'h0, BP_TIME_MAX}) ? BP_TIME_MAX : pwdata[13:0];
                end
                ADDR_OFF_THR: off_thr_ff <= clamp10(pwdata, TSEC_MAX);
                ADDR_ON_LONG: on_long_ff <= clamp10(pwdata, TSEC_MAX);
                ADDR_ON_SHORT: on_short_ff <= clamp10(pwdata, TSEC_MAX);
                ADDR_SHUTOFF: begin
                    shutoff_ff <= (pwdata > {23'h0, SHUTOFF_MAX}) ? SHUTOFF_MAX : pwdata[8:0];
                end
                ADDR_MINFREQ: minfreq_ff <= pwdata[8:0];
                ADDR_IRQ_EN: irq_en_ff <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // one-second and one-minute tick
    logic [31:0] div_ff;
    logic [5:0] secs_ff;
    logic sec_tick_ff, min_tick_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 32'h0;
            secs_ff <= 6'h00;
            sec_tick_ff <= 1'b0;
            min_tick_ff <= 1'b0;
        end else begin
            sec_tick_ff <= (div_ff == SEC_DIV - 1);
            div_ff <= (div_ff == SEC_DIV - 1) ? 32'h0 : div_ff + 32'h1;
            min_tick_ff <= 1'b0;
            if (sec_tick_ff) begin
                if (secs_ff == 6'(MIN_SECONDS - 1)) begin
                    secs_ff <= 6'h00;
                    min_tick_ff <= 1'b1;
                end else begin
                    secs_ff <= secs_ff + 6'h01;
                end
            end
        end
    end

    // operating mode: hand refused while locked
    prs_mode_e mode_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mode_ff <= PRS_AUTO;
        else if (hand_req_ff && !lock_ff) mode_ff <= PRS_HAND;
        else if (auto_req_ff) mode_ff <= PRS_AUTO;
        else if (hand_req_ff || mode_ff == PRS_HAND && lock_ff) mode_ff <= PRS_OFF;
        else mode_ff <= mode_ff;
    end
    assign op_mode = mode_ff;

    // contact decode
    wire run1 = (sel1_ff == SEL_ALWAYS) | ((sel1_ff == SEL_CLOSED_RUN) ? c1 : ~c1);
    wire run2 = (sel2_ff == SEL_CLOSED_RUN) ? c2 :
        (sel2_ff == SEL_CLOSED_STOP) ? ~c2 : 1'b1;
    wire latch_set = (sel2_ff == SEL_LATCH) & ~c2;
    wire want_run = (mode_ff == PRS_HAND) |
        ((mode_ff == PRS_AUTO) & run1 & run2 & ~status_ff[ST_LATCH]);

    // broken pipe: minutes below threshold, cp only
    logic [13:0] bp_cnt_ff;
    wire bp_arm = cp & (bp_psi_ff != 8'h00) & (pressure_psi < {1'b0, bp_psi_ff});
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) bp_cnt_ff <= 14'h0;
        else if (!bp_arm) bp_cnt_ff <= 14'h0;
        else if (min_tick_ff && bp_cnt_ff < bp_time_ff) bp_cnt_ff <= bp_cnt_ff + 14'h1;
    end
    wire bp_event = bp_arm & (bp_cnt_ff >= bp_time_ff);

    // sleep and anti-short-cycle
    logic [9:0] on_cnt_ff, off_cnt_ff, min_on_ff;
    wire [9:0] sleep_f = 10'(minfreq_ff) + 10'(shutoff_ff);
    wire sleep_req = cp & at_setpoint & ({1'b0, output_freq_hz} <= sleep_f);
    wire stop_req = ~want_run | status_ff[ST_BROKEN] | sleep_req;
    wire hold_on = cp & motor_run & (on_cnt_ff < min_on_ff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_run <= 1'b0;
            on_cnt_ff <= 10'h0;
            off_cnt_ff <= 10'h0;
            min_on_ff <= ON_LONG_RST;
        end else begin
            // latch fault and explicit stop override the on timer
            if (!motor_run) begin
                if (!stop_req) begin
                    motor_run <= 1'b1;
                    on_cnt_ff <= 10'h0;
                    min_on_ff <= (off_cnt_ff > off_thr_ff) ? on_long_ff : on_short_ff;
                end else if (sec_tick_ff && off_cnt_ff < TSEC_MAX) begin
                    off_cnt_ff <= off_cnt_ff + 10'h1;
                end
            end else begin
                if (stop_req && !hold_on || !want_run || status_ff[ST_BROKEN]) begin
                    motor_run <= 1'b0;
                    off_cnt_ff <= 10'h0;
                end else if (sec_tick_ff && on_cnt_ff < TSEC_MAX) begin
                    on_cnt_ff <= on_cnt_ff + 10'h1;
                end
            end
        end
    end

    // reverse while input two open in mode three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) motor_reverse <= 1'b0;
        else motor_reverse <= (sel2_ff == SEL_REVERSE) & ~c2;
    end

    // sticky status, set wins over clear; enter clears latch once contact closed
    wire [2:0] ev = {sleep_req, bp_event, latch_set};
    wire [2:0] clr = (wr && paddr == ADDR_IRQ_CLR) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= ev | (status_ff & ~clr);
            if (enter_p && !latch_set && !rtc_edit_ff) status_ff[ST_LATCH] <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq <= 1'b0;
        else irq <= |(status_ff & irq_en_ff);
    end

    // real-time clock: mo dd yy hh mm ss, keypad edit
    logic [6:0] rtc_ff [6];
    logic [2:0] pos_ff;
    logic [6:0] lim [6];
    assign lim[0] = 7'd12;
    assign lim[1] = 7'd31;
    assign lim[2] = 7'd99;
    assign lim[3] = 7'd23;
    assign lim[4] = 7'd59;
    assign lim[5] = 7'd59;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 6; i++) rtc_ff[i] <= (i < 2) ? 7'h01 : 7'h00;
            pos_ff <= 3'h0;
            rtc_edit_ff <= 1'b0;
        end else if (wr && paddr == ADDR_RTC_KEY) begin
            rtc_edit_ff <= pwdata[0];
            pos_ff <= 3'h0;
        end else if (rtc_edit_ff) begin
            if (enter_p) begin
                if (pos_ff == 3'h5) rtc_edit_ff <= 1'b0;
                pos_ff <= (pos_ff == 3'h5) ? 3'h0 : pos_ff + 3'h1;
            end else if (up_p || dn_p) begin
                rtc_ff[pos_ff] <= bump(rtc_ff[pos_ff], up_p, lim[pos_ff]);
            end
        end else if (sec_tick_ff) begin
            // simple carry chain; day rolls at 31
            rtc_ff[5] <= (rtc_ff[5] == lim[5]) ? 7'h00 : rtc_ff[5] + 7'h01;
            if (rtc_ff[5] == lim[5]) begin
                rtc_ff[4] <= (rtc_ff[4] == lim[4]) ? 7'h00 : rtc_ff[4] + 7'h01;
                if (rtc_ff[4] == lim[4]) begin
                    rtc_ff[3] <= (rtc_ff[3] == lim[3]) ? 7'h00 : rtc_ff[3] + 7'h01;
                    if (rtc_ff[3] == lim[3]) begin
                        rtc_ff[1] <= (rtc_ff[1] == lim[1]) ? 7'h01 : rtc_ff[1] + 7'h01;
                        if (rtc_ff[1] == lim[1]) begin
                            rtc_ff[0] <= (rtc_ff[0] == lim[0]) ? 7'h01 : rtc_ff[0] + 7'h01;
                        end
                    end
                end
            end
        end
    end

    // apb read path, one wait-free access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > ADDR_RTC_KEY | paddr[1:0] != 2'h0);
            prdata <= 32'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ADDR_CTRL: prdata <= {25'h0, cfg_ff, 1'b0, 2'(mode_ff), lock_ff};
                    ADDR_SEL: prdata <= {26'h0, sel2_ff, 2'h0, sel1_ff};
                    ADDR_CONTRAST: prdata <= {26'h0, lcd_contrast};
                    ADDR_BP_PSI: prdata <= {24'h0, bp_psi_ff};
                    ADDR_BP_TIME: prdata <= {18'h0, bp_time_ff};
                    ADDR_OFF_THR: prdata <= {22'h0, off_thr_ff};
                    ADDR_ON_LONG: prdata <= {22'h0, on_long_ff};
                    ADDR_ON_SHORT: prdata <= {22'h0, on_short_ff};
                    ADDR_SHUTOFF: prdata <= {23'h0, shutoff_ff};
                    ADDR_MINFREQ: prdata <= {23'h0, minfreq_ff};
                    ADDR_STATUS: prdata <= {27'h0, motor_run, motor_reverse, status_ff};
                    ADDR_IRQ_EN: prdata <= {29'h0, irq_en_ff};
                    ADDR_DATE: prdata <= {11'h0, rtc_ff[0], rtc_ff[1], rtc_ff[2]};
                    ADDR_TIME: prdata <= {11'h0, rtc_ff[3], rtc_ff[4], rtc_ff[5]};
                    ADDR_RTC_KEY: prdata <= {28'h0, pos_ff, rtc_edit_ff};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
    wire unused_rd = rd;

    property p_lock;
        @(posedge pclk) disable iff (!presetn) lock_ff |=> mode_ff != PRS_HAND || $past(!lock_ff);
    endproperty
    a_lock: assert property (p_lock) else $error("hand mode while locked");
    property p_latch;
        @(posedge pclk) disable iff (!presetn) latch_set |=> status_ff[ST_LATCH];
    endproperty
    a_latch: assert property (p_latch) else $error("latch fault not set");
    property p_latch_stop;
        @(posedge pclk) disable iff (!presetn) status_ff[ST_LATCH] && mode_ff == PRS_AUTO |=> !motor_run;
    endproperty
    a_latch_stop: assert property (p_latch_stop) else $error("run during latch fault");
    property p_rev;
        @(posedge pclk) disable iff (!presetn) (sel2_ff == SEL_REVERSE && !c2) |=> motor_reverse;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse missing");
    property p_contrast;
        @(posedge pclk) disable iff (!presetn) lcd_contrast >= CONTRAST_MIN;
    endproperty
    a_contrast: assert property (p_contrast) else $error("contrast out of range");
    property p_bp_off;
        @(posedge pclk) disable iff (!presetn) bp_psi_ff == 8'h00 |-> !bp_event;
    endproperty
    a_bp_off: assert property (p_bp_off) else $error("broken pipe while disabled");
    property p_cp;
        @(posedge pclk) disable iff (!presetn) !cp |-> !sleep_req && !bp_event && !hold_on;
    endproperty
    a_cp: assert property (p_cp) else $error("cp feature outside cp");
    property p_sec;
        @(posedge pclk) disable iff (!presetn) sec_tick_ff |=> !sec_tick_ff;
    endproperty
    a_sec: assert property (p_sec) else $error("tick too long");
endmodule
`default_nettype wire

// File: tb/prs_field.sv
`timescale 1ns/10ps
`default_nettype none
// field contacts and keypad operator in front of the supervisor
module prs_field (
    input wire logic pclk,
    input wire logic want_one_closed,
    input wire logic want_two_closed,
    input wire logic enter_req,
    output logic contact_one_closed,
    output logic contact_two_closed,
    output logic key_enter,
    output logic key_up,
    output logic key_down
);
    logic [2:0] hold_ff;
    // contacts start closed and follow the command one edge later
    initial begin
        contact_one_closed = 1'b1;
        contact_two_closed = 1'b1;
        hold_ff = 3'h0;
    end
    always @(posedge pclk) begin
        contact_one_closed <= want_one_closed;
        contact_two_closed <= want_two_closed;
    end
    // a press is held long enough for the key synchroniser to see it
    always @(posedge pclk) begin
        if (enter_req) begin
            hold_ff <= 3'h6;
        end else if (hold_ff != 3'h0) begin
            hold_ff <= hold_ff - 3'h1;
        end
    end
    assign key_enter = (hold_ff != 3'h0);
    // the operator never edits the clock digits here
    assign key_up = 1'b0;
    assign key_down = 1'b0;
endmodule
`default_nettype wire

// File: tb/prs_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module prs_top_test;
    import prs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic one_cmd, two_cmd, enter_req, c1, c2, k_en, k_up, k_dn, at_setpoint;
    logic [8:0] pressure_psi, output_freq_hz;
    logic motor_run, motor_reverse, irq;
    logic [5:0] lcd_contrast;
    logic [1:0] op_mode;
    int mismatches = 0;
    int n_checks = 0;
    prs_top #(.SEC_DIV(10)) i_prs_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .contact_one_closed(c1), .contact_two_closed(c2),
        .key_enter(k_en), .key_up(k_up), .key_down(k_dn), .pressure_psi(pressure_psi),
        .output_freq_hz(output_freq_hz), .at_setpoint(at_setpoint), .motor_run(motor_run),
        .motor_reverse(motor_reverse), .lcd_contrast(lcd_contrast), .op_mode(op_mode),
        .irq(irq)
    );
    prs_field i_prs_field (
        .pclk(pclk), .want_one_closed(one_cmd), .want_two_closed(two_cmd),
        .enter_req(enter_req), .contact_one_closed(c1), .contact_two_closed(c2),
        .key_enter(k_en), .key_up(k_up), .key_down(k_dn)
    );
    // clock at 4 ns
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h1, 32'h0);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        conclude();
    end
    // main sequence
    initial begin
        logic [31:0] q;
        logic err;
        logic e;
        int m;
        logic [7:0] ra [8] = '{ADDR_SEL, ADDR_CONTRAST, ADDR_BP_PSI, ADDR_BP_TIME,
                               ADDR_OFF_THR, ADDR_ON_LONG, ADDR_ON_SHORT, ADDR_SHUTOFF};
        logic [31:0] rv [8] = '{32'h11, 32'h28, 32'h0, 32'h0, 32'h1e, 32'hf, 32'h3c, 32'hc};
        presetn = 1'b0;
        {psel, penable, pwrite, enter_req, at_setpoint} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {one_cmd, two_cmd} = 2'b11;
        pressure_psi = 9'h064;
        output_freq_hz = 9'h02a;
        cyc(16);
        presetn <= 1'b1;
        chk({30'h0, op_mode}, {30'h0, PRS_AUTO});
        chk({26'h0, lcd_contrast}, 32'h28);
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], q);
            chk(q, rv[i]);
        end
        $display("test reset values done");
        // selector decoding in config zero
        for (int s = 0; s < 5; s++) begin
            for (int c = 0; c < 2; c++) begin
                m = (s < 3) ? s : s - 3;
                wr(ADDR_SEL, (s < 3) ? s : 32'h2 | (m << 4));
                one_cmd <= c[0];
                two_cmd <= (s < 3) ? 1'b1 : c[0];
                cyc(8);
                e = (m == 2) || ((m == 0) == (c == 1));
                chk({31'h0, motor_run}, {31'h0, e});
            end
        end
        $display("test selectors done");
        // latching stop on input two with interrupt
        wr(ADDR_SEL, 32'h22);
        wr(ADDR_IRQ_EN, 32'h1);
        one_cmd <= 1'b1;
        two_cmd <= 1'b1;
        cyc(8);
        chk({31'h0, motor_run}, 32'h1);
        two_cmd <= 1'b0;
        cyc(8);
        chk({30'h0, motor_run, irq}, 32'h1);
        two_cmd <= 1'b1;
        cyc(8);
        chk({31'h0, motor_run}, 32'h0);
        rd(ADDR_STATUS, q);
        chk({31'h0, q[ST_LATCH]}, 32'h1);
        enter_req <= 1'b1;
        cyc(1);
        enter_req <= 1'b0;
        cyc(14);
        chk({31'h0, motor_run}, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_EN, 32'h0);
        two_cmd <= 1'b0;
        cyc(8);
        chk({31'h0, irq}, 32'h0);
        $display("test latch done");
        // reverse on open input two
        wr(ADDR_SEL, 32'h32);
        cyc(8);
        chk({31'h0, motor_reverse}, 32'h1);
        two_cmd <= 1'b1;
        cyc(8);
        chk({31'h0, motor_reverse}, 32'h0);
        $display("test reverse done");
        // contrast clamp and unmapped access
        wr(ADDR_CONTRAST, 32'h0a);
        cyc(2);
        chk({26'h0, lcd_contrast}, {26'h0, CONTRAST_MIN});
        wr(ADDR_CONTRAST, 32'h3f);
        cyc(2);
        chk({26'h0, lcd_contrast}, 32'h3f);
        apb(1'b0, 8'h40, 32'h0, q, err);
        chk({31'h0, err}, 32'h1);
        $display("test contrast done");
        // manual lockout
        wr(ADDR_CTRL, 32'h3);
        cyc(3);
        chk({30'h0, op_mode}, {30'h0, PRS_OFF});
        wr(ADDR_CTRL, 32'h2);
        cyc(3);
        chk({30'h0, op_mode}, {30'h0, PRS_HAND});
        wr(ADDR_CTRL, 32'h5);
        cyc(3);
        chk({30'h0, op_mode}, {30'h0, PRS_AUTO});
        $display("test lockout done");
        // sleep threshold, ignored outside constant pressure
        wr(ADDR_MINFREQ, 32'h1e);
        at_setpoint <= 1'b1;
        pressure_psi <= 9'h014;
        cyc(1500);
        rd(ADDR_STATUS, q);
        chk({30'h0, q[ST_SLEEP], q[ST_BROKEN]}, 32'h0);
        wr(ADDR_CTRL, 32'h15);
        output_freq_hz <= 9'h02b;
        cyc(8);
        rd(ADDR_STATUS, q);
        chk({31'h0, q[ST_SLEEP]}, 32'h0);
        output_freq_hz <= 9'h02a;
        cyc(8);
        rd(ADDR_STATUS, q);
        chk({31'h0, q[ST_SLEEP]}, 32'h1);
        $display("test sleep done");
        // broken pipe: zero threshold disables, else minutes below threshold
        wr(ADDR_BP_TIME, 32'h2);
        cyc(1500);
        rd(ADDR_STATUS, q);
        chk({31'h0, q[ST_BROKEN]}, 32'h0);
        wr(ADDR_BP_PSI, 32'h32);
        cyc(500);
        rd(ADDR_STATUS, q);
        chk({31'h0, q[ST_BROKEN]}, 32'h0);
        cyc(900);
        rd(ADDR_STATUS, q);
        chk({31'h0, q[ST_BROKEN]}, 32'h1);
        $display("test broken pipe done");
        // clock entry: enter moves the edit position right
        wr(ADDR_RTC_KEY, 32'h1);
        enter_req <= 1'b1;
        cyc(1);
        enter_req <= 1'b0;
        cyc(12);
        rd(ADDR_RTC_KEY, q);
        chk(q, 32'h3);
        $display("test clock entry done");
        conclude();
    end
endmodule
`default_nettype wire
